// *** verilog/dfd_map.vh ***
// constants for the descriptor flag decoder: bit positions, opcodes, register map, codes
// assumes it is included by its bare name from the decoder sources
`ifndef DFD_MAP_VH
`define DFD_MAP_VH

// ****************************************
// flag bit positions
// ****************************************
`define DFD_FLAG_ADDR2_TC 10
`define DFD_FLAG_ADDR1_TC 9
`define DFD_FLAG_CACHE 8
`define DFD_FLAG_CHECK 7
`define DFD_FLAG_RSV_HI 6
`define DFD_FLAG_RSV_LO 5

// ****************************************
// operation codes
// ****************************************
`define DFD_OP_NOOP 8'h00
`define DFD_OP_BATCH 8'h01
`define DFD_OP_DRAIN 8'h02
`define DFD_OP_MOVE 8'h03
`define DFD_OP_FILL 8'h04
`define DFD_OP_COMPARE 8'h05
`define DFD_OP_CMP_PAT 8'h06
`define DFD_OP_MK_DELTA 8'h07
`define DFD_OP_AP_DELTA 8'h08
`define DFD_OP_DUALCAST 8'h09
`define DFD_OP_XLT_FETCH 8'h0A
`define DFD_OP_CRC_GEN 8'h10
`define DFD_OP_COPY_CRC 8'h11
`define DFD_OP_DIF_CHK 8'h12
`define DFD_OP_DIF_INS 8'h13
`define DFD_OP_DIF_STRIP 8'h14
`define DFD_OP_DIF_UPD 8'h15
`define DFD_OP_DIX_GEN 8'h17
`define DFD_OP_FLUSH 8'h20
`define DFD_OP_UPD_WIN 8'h21
`define DFD_OP_ID_COPY 8'h23
`define DFD_OP_ID_FILL 8'h24
`define DFD_OP_ID_CMP 8'h25
`define DFD_OP_ID_CMP_PAT 8'h26

// ****************************************
// access kinds for address slots 1 and 2
// ****************************************
`define DFD_A1_NONE 3'h0
`define DFD_A1_SRC_RD 3'h1
`define DFD_A1_LIST_RD 3'h2
`define DFD_A1_SRC1_RD 3'h3
`define DFD_A1_RB1 3'h4
`define DFD_A1_DELTA_RD 3'h5
`define DFD_A2_NONE 3'h0
`define DFD_A2_DST_WR 3'h1
`define DFD_A2_DST1_WR 3'h2
`define DFD_A2_SRC2_RD 3'h3
`define DFD_A2_RB2 3'h4

// ****************************************
// completion status codes
// ****************************************
`define DFD_ST_SUCCESS 8'h01
`define DFD_ST_FALSE_PRED 8'h02
`define DFD_ST_BAD_FLAGS 8'h11

// ****************************************
// register map
// ****************************************
`define DFD_REG_GRP_CFG 8'h00
`define DFD_REG_GEN_CAP 8'h04
`define DFD_REG_IRQ_STAT 8'h08
`define DFD_REG_IRQ_MASK 8'h0C
`define DFD_REG_LAST 8'h10
`define DFD_GRP_TC1_LSB 0
`define DFD_GRP_TC2_LSB 4
`define DFD_CAP_CACHE_BIT 0
`define DFD_IRQ_DECODED 0
`define DFD_IRQ_REJECT 1
`define DFD_IRQ_CPL 2
`define DFD_IRQ_W 3
`define DFD_GRP_CFG_RST 32'h0000_0000
`define DFD_IRQ_MASK_RST 3'h0

`endif

// *** verilog/dfd_op_class.v ***
// operation classifier: what each opcode does with address slots and memory writes
// assumes a registered opcode from the same clock domain; purely combinational
`default_nettype none
`include "dfd_map.vh"

module dfd_op_class
(
  input wire [7:0] opcode_i,
  output reg known_o,
  output reg writes_mem_o,
  output reg result_op_o,
  output reg is_flush_o,
  output reg [2:0] a1_kind_o,
  output reg [2:0] a2_kind_o
);

  always @*
  begin
    known_o = 1'b1;
    writes_mem_o = 1'b0;
    result_op_o = 1'b0;
    is_flush_o = 1'b0;
    a1_kind_o = `DFD_A1_SRC_RD;
    a2_kind_o = `DFD_A2_NONE;
    case (opcode_i)
      `DFD_OP_NOOP: a1_kind_o = `DFD_A1_NONE;
      `DFD_OP_BATCH: a1_kind_o = `DFD_A1_LIST_RD;
      `DFD_OP_DRAIN:
      begin
        a1_kind_o = `DFD_A1_RB1;
        a2_kind_o = `DFD_A2_RB2;
      end
      `DFD_OP_MOVE, `DFD_OP_COPY_CRC, `DFD_OP_DIF_INS, `DFD_OP_DIF_STRIP,
      `DFD_OP_DIF_UPD, `DFD_OP_DIX_GEN, `DFD_OP_ID_COPY:
      begin
        writes_mem_o = 1'b1;
        a2_kind_o = `DFD_A2_DST_WR;
      end
      `DFD_OP_FILL, `DFD_OP_ID_FILL:
      begin
        writes_mem_o = 1'b1;
        a1_kind_o = `DFD_A1_NONE;
        a2_kind_o = `DFD_A2_DST_WR;
      end
      `DFD_OP_COMPARE, `DFD_OP_MK_DELTA:
      begin
        result_op_o = 1'b1;
        writes_mem_o = (opcode_i == `DFD_OP_MK_DELTA);
        a1_kind_o = `DFD_A1_SRC1_RD;
        a2_kind_o = `DFD_A2_SRC2_RD;
      end
      `DFD_OP_CMP_PAT: result_op_o = 1'b1;
      `DFD_OP_AP_DELTA:
      begin
        writes_mem_o = 1'b1;
        a1_kind_o = `DFD_A1_DELTA_RD;
        a2_kind_o = `DFD_A2_DST_WR;
      end
      `DFD_OP_DUALCAST:
      begin
        writes_mem_o = 1'b1;
        a2_kind_o = `DFD_A2_DST1_WR;
      end
      `DFD_OP_ID_CMP: a2_kind_o = `DFD_A2_SRC2_RD;
      `DFD_OP_XLT_FETCH, `DFD_OP_CRC_GEN, `DFD_OP_DIF_CHK, `DFD_OP_UPD_WIN,
      `DFD_OP_ID_CMP_PAT: a1_kind_o = `DFD_A1_SRC_RD;
      `DFD_OP_FLUSH:
      begin
        is_flush_o = 1'b1;
        a1_kind_o = `DFD_A1_NONE;
        a2_kind_o = `DFD_A2_DST_WR;
      end
      default:
      begin
        known_o = 1'b0;
        a1_kind_o = `DFD_A1_NONE;
      end
    endcase
  end

endmodule // dfd_op_class
`default_nettype wire

// *** verilog/dfd_flag_decoder.v ***
// descriptor flag decoder: traffic class routing, cache hint, result check, flag validation
// assumes descriptors and results come from logic on clk_sys_i; registers on a strobe port
`default_nettype none
`include "dfd_map.vh"

module dfd_flag_decoder
#(
  parameter TC_W = 3,
  parameter CACHE_CTRL_SUP = 1'b1
)
(
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg irq_o,
  input wire desc_valid_i,
  input wire [7:0] desc_opcode_i,
  input wire [23:0] desc_flags_i,
  output reg dec_valid_o,
  output reg dec_reject_o,
  output reg [2:0] a1_kind_o,
  output reg [TC_W-1:0] a1_tc_o,
  output reg [2:0] a2_kind_o,
  output reg [TC_W-1:0] a2_tc_o,
  output reg data_wr_cache_o,
  output reg cr_wr_cache_o,
  output reg check_en_o,
  input wire res_valid_i,
  input wire res_ok_i,
  input wire res_pred_i,
  input wire [7:0] res_err_code_i,
  output reg cpl_valid_o,
  output reg [7:0] cpl_status_o
);

  // ****************************************
  // helpers
  // ****************************************
  function [TC_W-1:0] pick_tc;
    input sel;
    input [TC_W-1:0] first_tc;
    input [TC_W-1:0] second_tc;
    begin
      pick_tc = sel ? second_tc : first_tc;
    end
  endfunction

  function hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      hit = (addr == offs);
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [TC_W-1:0] first_traffic_class_value_q;
  reg [TC_W-1:0] second_traffic_class_value_q;
  reg [`DFD_IRQ_W-1:0] irq_stat_q;
  reg [`DFD_IRQ_W-1:0] irq_stat_d;
  reg [`DFD_IRQ_W-1:0] irq_mask_q;
  reg [7:0] last_status_q;
  reg [7:0] last_viol_q;
  reg check_q;
  reg [31:0] rdata_d;

  wire known;
  wire writes_mem;
  wire result_op;
  wire is_flush;
  wire [2:0] a1_kind;
  wire [2:0] a2_kind;

  dfd_op_class u_class
  (
    .opcode_i(desc_opcode_i),
    .known_o(known),
    .writes_mem_o(writes_mem),
    .result_op_o(result_op),
    .is_flush_o(is_flush),
    .a1_kind_o(a1_kind),
    .a2_kind_o(a2_kind)
  );

  // ****************************************
  // reserved flag checks
  // ****************************************
  wire [31:0] general_capability_word;
  wire cache_sup;
  wire rsv_a2;
  wire rsv_a1;
  wire rsv_cache;
  wire rsv_check;
  wire rsv_pad;
  wire [7:0] viol;
  wire bad;

  assign general_capability_word = {31'h0000_0000, (CACHE_CTRL_SUP != 0)};
  assign cache_sup = general_capability_word[`DFD_CAP_CACHE_BIT];
  // bit 10 reserved when neither destination, first destination, second source nor second readback is used
  assign rsv_a2 = (a2_kind == `DFD_A2_NONE) && desc_flags_i[`DFD_FLAG_ADDR2_TC];
  assign rsv_a1 = (a1_kind == `DFD_A1_NONE) && desc_flags_i[`DFD_FLAG_ADDR1_TC];
  assign rsv_cache = desc_flags_i[`DFD_FLAG_CACHE] &&
    (!cache_sup || is_flush || !writes_mem);
  assign rsv_check = desc_flags_i[`DFD_FLAG_CHECK] && !result_op;
  assign rsv_pad = |desc_flags_i[`DFD_FLAG_RSV_HI:`DFD_FLAG_RSV_LO];
  assign viol = {3'h0, rsv_pad, rsv_check, rsv_cache, rsv_a1, rsv_a2};
  // an unknown opcode is refused the same way as a reserved flag
  assign bad = |viol || !known;

  // ****************************************
  // register access
  // ****************************************
  wire wr_grp;
  wire wr_stat;
  wire wr_mask;
  wire [`DFD_IRQ_W-1:0] ev;
  wire [`DFD_IRQ_W-1:0] w1c;
  wire cpl_from_res;
  wire rej_now;
  wire acc_now;
  wire cpl_now;
  wire [`DFD_IRQ_W-1:0] mask_next;
  reg irq_d;

  assign rej_now = desc_valid_i && bad;
  assign acc_now = desc_valid_i && !bad;
  assign wr_grp = reg_wr_i && hit(reg_addr_i, `DFD_REG_GRP_CFG);
  assign wr_stat = reg_wr_i && hit(reg_addr_i, `DFD_REG_IRQ_STAT);
  assign wr_mask = reg_wr_i && hit(reg_addr_i, `DFD_REG_IRQ_MASK);
  // a rejection owns the completion slot; a result in the same cycle is dropped
  assign cpl_from_res = res_valid_i && !rej_now;
  assign cpl_now = rej_now || cpl_from_res;
  assign ev[`DFD_IRQ_DECODED] = acc_now;
  assign ev[`DFD_IRQ_REJECT] = rej_now;
  assign ev[`DFD_IRQ_CPL] = cpl_now;
  assign w1c = wr_stat ? reg_wdata_i[`DFD_IRQ_W-1:0] : {`DFD_IRQ_W{1'b0}};
  assign mask_next = wr_mask ? reg_wdata_i[`DFD_IRQ_W-1:0] : irq_mask_q;

  always @*
  begin
    // the set of an event wins over a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~w1c) | ev;
    // the level output looks ahead at the next status and the next mask
    irq_d = |(irq_stat_d & mask_next);
  end

  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `DFD_REG_GRP_CFG:
        begin
          rdata_d[`DFD_GRP_TC1_LSB +: TC_W] = first_traffic_class_value_q;
          rdata_d[`DFD_GRP_TC2_LSB +: TC_W] = second_traffic_class_value_q;
        end
        `DFD_REG_GEN_CAP: rdata_d = general_capability_word;
        `DFD_REG_IRQ_STAT: rdata_d[`DFD_IRQ_W-1:0] = irq_stat_q;
        `DFD_REG_IRQ_MASK: rdata_d[`DFD_IRQ_W-1:0] = irq_mask_q;
        `DFD_REG_LAST: rdata_d[15:0] = {last_viol_q, last_status_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      first_traffic_class_value_q <= {TC_W{1'b0}};
      second_traffic_class_value_q <= {TC_W{1'b0}};
      irq_mask_q <= `DFD_IRQ_MASK_RST;
      reg_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      if (wr_grp)
      begin
        first_traffic_class_value_q <= reg_wdata_i[`DFD_GRP_TC1_LSB +: TC_W];
        second_traffic_class_value_q <= reg_wdata_i[`DFD_GRP_TC2_LSB +: TC_W];
      end
      if (wr_mask)
      begin
        irq_mask_q <= reg_wdata_i[`DFD_IRQ_W-1:0];
      end
      reg_rdata_o <= rdata_d;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_stat_q <= {`DFD_IRQ_W{1'b0}};
      irq_o <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_o <= irq_d;
    end
  end

  // ****************************************
  // descriptor decode
  // ****************************************
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dec_valid_o <= 1'b0;
      dec_reject_o <= 1'b0;
      a1_kind_o <= `DFD_A1_NONE;
      a1_tc_o <= {TC_W{1'b0}};
      a2_kind_o <= `DFD_A2_NONE;
      a2_tc_o <= {TC_W{1'b0}};
      data_wr_cache_o <= 1'b0;
      cr_wr_cache_o <= 1'b0;
      check_en_o <= 1'b0;
      check_q <= 1'b0;
      last_viol_q <= 8'h00;
    end
    else
    begin
      dec_valid_o <= desc_valid_i;
      dec_reject_o <= rej_now;
      if (desc_valid_i)
      begin
        last_viol_q <= viol;
        a1_kind_o <= bad ? `DFD_A1_NONE : a1_kind;
        a2_kind_o <= bad ? `DFD_A2_NONE : a2_kind;
        // classes follow the flags even on a reject; the kinds carry the verdict
        a1_tc_o <= pick_tc(desc_flags_i[`DFD_FLAG_ADDR1_TC], first_traffic_class_value_q,
          second_traffic_class_value_q);
        a2_tc_o <= pick_tc(desc_flags_i[`DFD_FLAG_ADDR2_TC], first_traffic_class_value_q,
          second_traffic_class_value_q);
        data_wr_cache_o <= !bad && writes_mem && desc_flags_i[`DFD_FLAG_CACHE];
        cr_wr_cache_o <= 1'b1;
        check_en_o <= !bad && result_op && desc_flags_i[`DFD_FLAG_CHECK];
        // a rejected descriptor never runs, so its check flag is not kept
        if (!bad)
        begin
          check_q <= result_op && desc_flags_i[`DFD_FLAG_CHECK];
        end
      end
    end
  end

  // ****************************************
  // completion status
  // ****************************************
  reg [7:0] status_d;

  always @*
  begin
    status_d = `DFD_ST_SUCCESS;
    if (rej_now)
    begin
      status_d = `DFD_ST_BAD_FLAGS;
    end
    else if (!res_ok_i)
    begin
      status_d = res_err_code_i;
    end
    else if (check_q && !res_pred_i)
    begin
      status_d = `DFD_ST_FALSE_PRED;
    end
    else
    begin
      status_d = `DFD_ST_SUCCESS;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cpl_valid_o <= 1'b0;
      cpl_status_o <= 8'h00;
      last_status_q <= 8'h00;
    end
    else
    begin
      cpl_valid_o <= cpl_now;
      if (cpl_now)
      begin
        cpl_status_o <= status_d;
        last_status_q <= status_d;
      end
    end
  end

endmodule // dfd_flag_decoder
`default_nettype wire

// *** verif/dfd_flag_decoder_properties.sv ***
// checker for the descriptor flag decoder: timing and decode relations at the ports
// assumes it is bound to dfd_flag_decoder, one clock, asynchronous active-low reset
`default_nettype none

module dfd_flag_decoder_properties
#(
  parameter TC_W = 3
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic desc_valid_i,
  input wire logic [7:0] desc_opcode_i,
  input wire logic [23:0] desc_flags_i,
  input wire logic dec_valid_o,
  input wire logic dec_reject_o,
  input wire logic [2:0] a1_kind_o,
  input wire logic [TC_W-1:0] a1_tc_o,
  input wire logic [2:0] a2_kind_o,
  input wire logic [TC_W-1:0] a2_tc_o,
  input wire logic data_wr_cache_o,
  input wire logic cr_wr_cache_o,
  input wire logic check_en_o,
  input wire logic res_valid_i,
  input wire logic res_ok_i,
  input wire logic res_pred_i,
  input wire logic cpl_valid_o,
  input wire logic [7:0] cpl_status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // shadow of the group configuration word
  logic [31:0] cfg_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
      cfg_q <= 32'h0;
    else if (reg_wr_i && reg_addr_i == 8'h00)
      cfg_q <= reg_wdata_i;

  // check flag of the last accepted descriptor; a rejected one leaves it alone
  logic acc_chk_q;
  logic cur_chk;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
      acc_chk_q <= 1'b0;
    else if (dec_valid_o && !dec_reject_o)
      acc_chk_q <= check_en_o;
  assign cur_chk = (dec_valid_o && !dec_reject_o) ? check_en_o : acc_chk_q;

  sequence s_checked_miss;
    res_valid_i && res_ok_i && !res_pred_i && cur_chk && !desc_valid_i;
  endsequence
  sequence s_plain_ok;
    res_valid_i && res_ok_i && !cur_chk && !desc_valid_i;
  endsequence

  a_dec_latency: assert property (desc_valid_i |=> dec_valid_o)
    else $error("decode result missing one cycle after descriptor");
  a_dec_spurious: assert property (!desc_valid_i |=> !dec_valid_o)
    else $error("decode result without descriptor");
  a_tc1_select: assert property (desc_valid_i |=> a1_tc_o == ($past(desc_flags_i[9]) ?
    $past(cfg_q[4+:TC_W]) : $past(cfg_q[TC_W-1:0])))
    else $error("slot one traffic class wrong");
  a_tc2_select: assert property (desc_valid_i |=> a2_tc_o == ($past(desc_flags_i[10]) ?
    $past(cfg_q[4+:TC_W]) : $past(cfg_q[TC_W-1:0])))
    else $error("slot two traffic class wrong");
  a_cr_cache: assert property (dec_valid_o |-> cr_wr_cache_o)
    else $error("completion record write not to cache");
  a_rsv_zero: assert property (desc_valid_i && desc_flags_i[6:5] != 2'h0 |=> dec_reject_o)
    else $error("nonzero bits 6:5 accepted");
  a_check_gate: assert property (desc_valid_i && desc_flags_i[7] &&
    !(desc_opcode_i inside {8'h05, 8'h06, 8'h07}) |=> dec_reject_o)
    else $error("result check accepted on wrong operation");
  a_bit9_rsv: assert property (desc_valid_i && desc_flags_i[9] &&
    desc_opcode_i inside {8'h00, 8'h04, 8'h20} |=> dec_reject_o)
    else $error("bit 9 accepted where reserved");
  a_reject_cpl: assert property (dec_valid_o && dec_reject_o |-> cpl_valid_o &&
    cpl_status_o == 8'h11 && a1_kind_o == 3'h0 && a2_kind_o == 3'h0)
    else $error("rejection not reported as invalid flags");
  a_hint_follow: assert property (dec_valid_o && !dec_reject_o |->
    data_wr_cache_o == $past(desc_flags_i[8]))
    else $error("cache hint does not follow bit 8");
  a_false_pred: assert property (s_checked_miss |=> cpl_valid_o && cpl_status_o == 8'h02)
    else $error("false predicate not reported");
  a_plain_ok: assert property (s_plain_ok |=> cpl_valid_o && cpl_status_o == 8'h01)
    else $error("unchecked success not reported as success");
endmodule // dfd_flag_decoder_properties

`default_nettype wire

// *** verif/dfd_exec_model.sv ***
// execution engine stand-in: returns one result per go pulse after lat_i cycles
// assumes go_i pulses one cycle and lat_i is at least 1
`default_nettype none

module dfd_exec_model
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [3:0] lat_i,
  input wire logic ok_i,
  input wire logic pred_i,
  input wire logic [7:0] err_i,
  output logic res_valid_o,
  output logic res_ok_o,
  output logic res_pred_o,
  output logic [7:0] res_err_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [9:0] hold_q;
  // outside the valid pulse the result lines toggle, so stale values never match
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 4'h0;
      hold_q <= 10'h0;
      res_valid_o <= 1'b0;
      {res_ok_o, res_pred_o, res_err_code_o} <= 10'h0;
    end
    else
    begin
      res_valid_o <= (cnt_q == 4'h1);
      if (cnt_q == 4'h1)
        {res_ok_o, res_pred_o, res_err_code_o} <= hold_q;
      else
        {res_ok_o, res_pred_o, res_err_code_o} <= ~{res_ok_o, res_pred_o, res_err_code_o};
      if (go_i)
      begin
        cnt_q <= lat_i;
        hold_q <= {ok_i, pred_i, err_i};
      end
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // dfd_exec_model

`default_nettype wire

// *** verif/descriptor_flag_decoder_bench.sv ***
// self-checking bench for the descriptor flag decoder
// assumes the decoder defaults, group configuration written by the bench
`default_nettype none

module descriptor_flag_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic desc_valid_i = 1'b0;
  logic [7:0] desc_opcode_i = 8'h00;
  logic [23:0] desc_flags_i = 24'h0;
  logic go = 1'b0;
  logic ok = 1'b0;
  logic pred = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [7:0] err = 8'h00;
  logic res_valid_i, res_ok_i, res_pred_i;
  logic [7:0] res_err_code_i, cpl_status_o;
  logic [31:0] reg_rdata_o, d;
  logic irq_o, dec_valid_o, dec_reject_o, data_wr_cache_o, cr_wr_cache_o, check_en_o, cpl_valid_o;
  logic [2:0] a1_kind_o, a2_kind_o, a1_tc_o, a2_tc_o;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  dfd_flag_decoder u_dut (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .irq_o, .desc_valid_i, .desc_opcode_i, .desc_flags_i,
    .dec_valid_o, .dec_reject_o, .a1_kind_o, .a1_tc_o, .a2_kind_o, .a2_tc_o, .data_wr_cache_o,
    .cr_wr_cache_o, .check_en_o, .res_valid_i, .res_ok_i, .res_pred_i, .res_err_code_i,
    .cpl_valid_o, .cpl_status_o);
  dfd_exec_model u_exec (.clk_sys_i, .rst_b_i, .go_i(go), .lat_i(lat), .ok_i(ok), .pred_i(pred),
    .err_i(err), .res_valid_o(res_valid_i), .res_ok_o(res_ok_i), .res_pred_o(res_pred_i),
    .res_err_code_o(res_err_code_i));

  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic dsc(input logic [7:0] o, input logic [23:0] f);
    @(posedge clk_sys_i);
    {desc_valid_i, desc_opcode_i, desc_flags_i} <= {1'b1, o, f};
    @(posedge clk_sys_i);
    desc_valid_i <= 1'b0;
    #1;
  endtask
  task automatic res(input logic o, p, input logic [7:0] e, input logic [3:0] l, input logic [7:0] x);
    int n;
    @(posedge clk_sys_i);
    {go, ok, pred, err, lat} <= {1'b1, o, p, e, l};
    @(posedge clk_sys_i);
    go <= 1'b0;
    n = 0;
    #1;
    while (cpl_valid_o !== 1'b1 && n < 30)
    begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    chk({cpl_valid_o, cpl_status_o}, {1'b1, x});
  endtask

  task automatic s_regs;
    rd(8'h00);
    chk(d, 32'h0);
    rd(8'h04);
    chk(d, 32'h1);
    wr(8'h04, 32'h0);
    rd(8'h04);
    chk(d, 32'h1);
    rd(8'h40);
    chk(d, 32'h0);
    wr(8'h00, 32'h52);
    rd(8'h00);
    chk(d, 32'h52);
  endtask
  task automatic s_irq;
    wr(8'h0C, 32'h2);
    wr(8'h08, 32'h7);
    dsc(8'h0B, 24'h0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b1);
    rd(8'h08);
    chk(d, 32'h6);
    wr(8'h08, 32'h7);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b0);
    wr(8'h0C, 32'h0);
    dsc(8'h0B, 24'h0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(irq_o, 1'b0);
    rd(8'h08);
    chk(d, 32'h6);
    rd(8'h10);
    chk(d, 32'h11);
  endtask
  task automatic s_route;
    logic [7:0] ops [7] = '{8'h03, 8'h01, 8'h02, 8'h05, 8'h07, 8'h08, 8'h09};
    logic [2:0] k1 [7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h3, 3'h5, 3'h1};
    logic [2:0] k2 [7] = '{3'h1, 3'h0, 3'h4, 3'h3, 3'h3, 3'h1, 3'h2};
    logic [23:0] f;
    for (int i = 0; i < 14; i++)
    begin
      f = (i % 2 == 0) ? 24'h000200 : (k2[i/2] != 3'h0 ? 24'h000400 : 24'h0);
      dsc(ops[i/2], f);
      chk({dec_valid_o, dec_reject_o, a1_kind_o}, {2'h2, k1[i/2]});
      chk(a2_kind_o, k2[i/2]);
      chk({a1_tc_o, a2_tc_o}, {f[9] ? 3'h5 : 3'h2, f[10] ? 3'h5 : 3'h2});
    end
    dsc(8'h03, 24'h000100);
    chk({data_wr_cache_o, cr_wr_cache_o}, 2'h3);
    dsc(8'h03, 24'h0);
    chk({data_wr_cache_o, cr_wr_cache_o}, 2'h1);
  endtask
  task automatic s_reject;
    logic [7:0] ops [8] = '{8'h00, 8'h04, 8'h20, 8'h06, 8'h03, 8'h03, 8'h01, 8'h0B};
    logic [23:0] fs [8] = '{24'h200, 24'h200, 24'h100, 24'h400, 24'h080, 24'h020, 24'h400, 24'h0};
    for (int i = 0; i < 8; i++)
    begin
      dsc(ops[i], fs[i]);
      chk({dec_valid_o, dec_reject_o, cpl_valid_o, a1_kind_o, a2_kind_o}, 9'h1C0);
      chk(cpl_status_o, 8'h11);
    end
  endtask
  task automatic s_result;
    for (int i = 5; i < 8; i++)
    begin
      dsc(i[7:0], 24'h000080);
      chk({dec_reject_o, check_en_o}, 2'h1);
    end
    dsc(8'h05, 24'h000080);
    res(1'b1, 1'b0, 8'h00, 4'h1, 8'h02);
    res(1'b1, 1'b1, 8'h00, 4'h9, 8'h01);
    res(1'b0, 1'b0, 8'h33, 4'h1, 8'h33);
    dsc(8'h05, 24'h0);
    res(1'b1, 1'b0, 8'h00, 4'h3, 8'h01);
  endtask

  task automatic finish_test;
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    s_regs();
    s_irq();
    s_route();
    s_reject();
    s_result();
    finish_test();
  end
endmodule // descriptor_flag_decoder_bench

bind dfd_flag_decoder dfd_flag_decoder_properties #(.TC_W(TC_W)) u_props (.clk_sys_i, .rst_b_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .desc_valid_i, .desc_opcode_i, .desc_flags_i,
  .dec_valid_o, .dec_reject_o, .a1_kind_o, .a1_tc_o, .a2_kind_o, .a2_tc_o, .data_wr_cache_o,
  .cr_wr_cache_o, .check_en_o, .res_valid_i, .res_ok_i, .res_pred_i, .cpl_valid_o, .cpl_status_o);

`default_nettype wire
